// File: hdl/rsc_host.sv
// host end: drives the serial link and the control pins
`include "rsc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module rsc_host (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // software port
  input  wire logic [3:0]   addr,
  input  wire logic [15:0]  wdata,
  input  wire logic         wr,
  input  wire logic         rd,
  output logic [15:0]       rdata,
  // link to radio
  rsc_if.host               link
);
  import rsc_pkg::*;

  logic [1:0]  ctrlReg;
  logic [1:0]  misoSync, mclkSync;
  logic        mclkPrev, clkSeen, busy, sclkReg, selNReg;
  logic [7:0]  halfCnt;
  logic [4:0]  bitCnt;
  logic [15:0] txShift;
  rsc_byte_t   rxShift, rxData;
  logic [15:0] rdataReg;

  wire startXfer = wr && addr == `RSC_HADDR_XFER && !busy && clkSeen;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      misoSync <= 2'h0;
      mclkSync <= 2'h0;
      mclkPrev <= 1'b0;
      clkSeen  <= 1'b0;
    end else begin
      misoSync <= {misoSync[0], link.miso};
      mclkSync <= {mclkSync[0], link.mclk};
      mclkPrev <= mclkSync[1];
      if (mclkSync[1] && !mclkPrev) clkSeen <= 1'b1; // see R16
    end
  end

  // ctrl bit0 drives sleep/transmit, bit1 asserts the reset pin; see R15
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrlReg <= 2'h0;
    end else if (wr && addr == `RSC_HADDR_CTRL) begin
      ctrlReg <= wdata[1:0]; // see R1
    end
  end

  // serial master: 16 bits, sample on rise, shift on fall
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy    <= 1'b0;
      selNReg <= 1'b1;
      sclkReg <= 1'b0;
      halfCnt <= 8'h00;
      bitCnt  <= 5'h00;
      txShift <= 16'h0000;
      rxShift <= 8'h00;
      rxData  <= 8'h00;
    end else if (startXfer) begin
      busy    <= 1'b1;
      selNReg <= 1'b0;
      halfCnt <= 8'h00;
      bitCnt  <= 5'h00;
      txShift <= wdata;
    end else if (busy) begin
      if (halfCnt < `RSC_HOST_HALF - 8'h01) begin
        halfCnt <= halfCnt + 8'h01;
      end else begin
        halfCnt <= 8'h00;
        if (bitCnt == 5'h10) begin
          busy    <= 1'b0;
          selNReg <= 1'b1;
          rxData  <= rxShift;
        end else if (!sclkReg) begin
          sclkReg <= 1'b1;
          rxShift <= {rxShift[6:0], misoSync[1]};
        end else begin
          sclkReg <= 1'b0;
          txShift <= {txShift[14:0], 1'b0};
          bitCnt  <= bitCnt + 5'h01;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdataReg <= 16'h0000;
    end else if (rd) begin
      case (addr)
        `RSC_HADDR_CTRL:   rdataReg <= {14'h0000, ctrlReg};
        `RSC_HADDR_STATUS: rdataReg <= {rxData, 6'h00, clkSeen, busy};
        default:           rdataReg <= 16'h0000;
      endcase
    end else begin
      rdataReg <= 16'h0000;
    end
  end

  assign rdata        = rdataReg;
  assign link.selN    = selNReg;
  assign link.sclk    = sclkReg;
  assign link.mosi    = txShift[15];
  assign link.sleepTx = ctrlReg[0];
  assign link.rstPinN = ~ctrlReg[1];
endmodule : rsc_host
`default_nettype wire

// File: hdl/rsc_radio.sv
// radio operating-state controller, device end
// Contract
// R1 - state changes by command or by pins
// R2 - report pending code during any transition
// R3 - host waits while pending code shows
// R4 - pin rise: idle-sleep, listen-noclk, synth-transmit
// R5 - pin fall: sleep-idle, noclk-listen
// R6 - pin reset: defaults, rate kept, go idle
// R7 - pin reset in power-on stays power-on
// R8 - forced idle everywhere but sleep, aborts busy
// R9 - plain idle waits for busy end
// R10 - forced synth-ready leaves busy, keeps analog on
// R11 - forced synth-ready ignored in idle, sleep, noclk
// R12 - host reads readback after each request
// R13 - power-on resets, clock out after oscillator
// R14 - input pulls only during power-on
// R15 - host sets pins before leaving power-on
// R16 - host waits for master clock before access
// R17 - power-on left by idle commands, wake event
// R18 - sleep after 35 clock cycles or immediately
// R19 - sleep keeps registers, clears buffer, engine
// R20 - idle: serial open, analog off, no pulls
// R21 - wake event on idle from reset, sleep
// R22 - regulator then synth, lock event
// R23 - listen at once, receive only after lock
// R24 - command and readback encodings are constants
`include "rsc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module rsc_radio (
  // clock and power-on reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // link to host
  rsc_if.dev                link,
  // analog and datapath status
  input  wire logic         oscReady,
  input  wire logic         synthLock,
  input  wire logic         frameStart,
  input  wire logic         activityDone,
  // analog and datapath controls
  output logic              analogRegEn,
  output logic              synthEn,
  output logic              rxEn,
  output logic              txEn,
  output logic              pullsEn,
  output logic              clearBuffers,
  output rsc_pkg::rsc_byte_t channel,
  // events
  output logic              wakeDoneEvt,
  output logic              synthLockEvt
);
  import rsc_pkg::*;

  logic [4:0] syncA, syncB;
  logic       sclkPrev, slpPrev, rstPrev, lockPrev;
  logic [4:0] bitCnt;
  rsc_byte_t  shiftIn, misoShift, ctrlReg, channelReg;
  logic [5:0] addrReg;
  logic       rwReg, cmdPulse, misoReg, wakeReg, lockEvtReg;
  rsc_code_t  cmdReg;
  rsc_state_t state, target;
  logic [7:0] mclkCnt;
  logic       mclkReg, mclkRise, idlePend, fromReset;
  logic [8:0] cnt;

  wire selN    = syncB[4];
  wire sclkS   = syncB[3];
  wire mosiS   = syncB[2];
  wire slp     = syncB[1];
  wire pinRst  = ~syncB[0];
  wire sRise   = sclkS & ~sclkPrev;
  wire sFall   = ~sclkS & sclkPrev;
  wire [2:0] rate = ctrlReg[`RSC_RATE_MSB:`RSC_RATE_LSB];
  wire stopped = (state == RSC_SLEEP) || (state == RSC_LISTEN_NC);
  wire mclkOn  = oscReady && (rate != `RSC_RATE_OFF) && !stopped;
  wire fastStop = mclkOn && (rate != `RSC_RATE_250K) && (rate != `RSC_RATE_62K);
  wire cmdForceIdle = cmdPulse && (cmdReg == `RSC_CMD_FORCE_IDLE);
  wire cmdIdle      = cmdPulse && (cmdReg == `RSC_CMD_IDLE);
  wire cmdAnyIdle   = cmdForceIdle || cmdIdle;

  function automatic logic isCmd(input rsc_code_t c);
    isCmd = cmdPulse && (cmdReg == c);
  endfunction : isCmd

  function automatic logic [7:0] halfPeriod(input logic [2:0] r);
    case (r)
      `RSC_RATE_2M:   halfPeriod = `RSC_HALF_2M;
      `RSC_RATE_250K: halfPeriod = `RSC_HALF_250K;
      `RSC_RATE_62K:  halfPeriod = `RSC_HALF_62K;
      default:        halfPeriod = `RSC_HALF_1M;
    endcase
  endfunction : halfPeriod

  function automatic rsc_code_t stateCode(input rsc_state_t s); // see R24
    case (s)
      RSC_POWER_ON:  stateCode = `RSC_ST_POWER_ON;
      RSC_SLEEP:     stateCode = `RSC_ST_SLEEP;
      RSC_IDLE:      stateCode = `RSC_ST_IDLE;
      RSC_SYN_RDY:   stateCode = `RSC_ST_SYN_RDY;
      RSC_LISTEN:    stateCode = `RSC_ST_LISTEN;
      RSC_LISTEN_NC: stateCode = `RSC_ST_LISTEN_NC;
      RSC_BUSY_RX:   stateCode = `RSC_ST_BUSY_RX;
      RSC_BUSY_TX:   stateCode = `RSC_ST_BUSY_TX;
      default:       stateCode = `RSC_ST_PENDING; // see R2
    endcase
  endfunction : stateCode

  function automatic rsc_byte_t regRead(input logic [5:0] a);
    case (a)
      `RSC_ADDR_READBACK: regRead = {3'h0, stateCode(state)}; // see R2
      `RSC_ADDR_COMMAND:  regRead = {3'h0, cmdReg};
      `RSC_ADDR_CTRL0:    regRead = ctrlReg;
      `RSC_ADDR_CHANNEL:  regRead = channelReg;
      default:            regRead = 8'h00;
    endcase
  endfunction : regRead

  // pin synchronisers: sel, sclk, mosi, sleep/transmit, reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      syncA <= 5'h11;
      syncB <= 5'h11;
    end else begin
      syncA <= {link.selN, link.sclk, link.mosi, link.sleepTx, link.rstPinN};
      syncB <= syncA;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclkPrev <= 1'b0;
      slpPrev  <= 1'b0;
      rstPrev  <= 1'b1;
      lockPrev <= 1'b0;
    end else begin
      sclkPrev <= sclkS;
      slpPrev  <= slp;
      rstPrev  <= syncB[0];
      lockPrev <= synthLock;
    end
  end

  // serial slave: header byte {rw, x, addr}, then data byte, msb first
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bitCnt    <= 5'h00;
      shiftIn   <= 8'h00;
      addrReg   <= 6'h00;
      rwReg     <= 1'b0;
      misoShift <= 8'h00;
    end else if (selN || !oscReady || pinRst) begin // see R13
      bitCnt <= 5'h00;
    end else if (sRise) begin
      shiftIn <= {shiftIn[6:0], mosiS};
      bitCnt  <= bitCnt + 5'h01;
      if (bitCnt == 5'h07) begin
        rwReg     <= shiftIn[6];
        addrReg   <= {shiftIn[4:0], mosiS};
        misoShift <= regRead({shiftIn[4:0], mosiS});
      end
    end else if (sFall && bitCnt > 5'h08) begin
      misoShift <= {misoShift[6:0], 1'b0};
    end
  end

  wire wrDone = sRise && !selN && oscReady && !pinRst && bitCnt == 5'h0F && rwReg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      misoReg <= 1'b0;
    end else begin
      misoReg <= misoShift[7];
    end
  end

  // registers; the rate bits survive a pin reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrlReg    <= `RSC_CTRL0_RST;
      channelReg <= `RSC_CHANNEL_RST;
      cmdReg     <= `RSC_CMD_NOP;
      cmdPulse   <= 1'b0;
    end else if (pinRst) begin
      ctrlReg    <= {5'(`RSC_CTRL0_RST >> 3), rate}; // see R6
      channelReg <= `RSC_CHANNEL_RST;
      cmdReg     <= `RSC_CMD_NOP;
      cmdPulse   <= 1'b0;
    end else begin
      cmdPulse <= wrDone && addrReg == `RSC_ADDR_COMMAND; // see R1
      if (wrDone && addrReg == `RSC_ADDR_COMMAND) cmdReg <= {shiftIn[3:0], mosiS};
      if (wrDone && addrReg == `RSC_ADDR_CTRL0) ctrlReg <= {shiftIn[6:0], mosiS};
      if (wrDone && addrReg == `RSC_ADDR_CHANNEL) channelReg <= {shiftIn[6:0], mosiS};
    end
  end

  // master clock output divider
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mclkCnt <= 8'h00;
      mclkReg <= 1'b0;
    end else if (!mclkOn) begin // see R13
      mclkCnt <= 8'h00;
      mclkReg <= 1'b0;
    end else if (mclkCnt >= halfPeriod(rate) - 8'h01) begin
      mclkCnt <= 8'h00;
      mclkReg <= ~mclkReg;
    end else begin
      mclkCnt <= mclkCnt + 8'h01;
    end
  end

  assign mclkRise = mclkOn && !mclkReg && mclkCnt >= halfPeriod(rate) - 8'h01;

  // operating-state machine
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state     <= RSC_POWER_ON; // see R13
      target    <= RSC_IDLE;
      cnt       <= 9'h000;
      idlePend  <= 1'b0;
      fromReset <= 1'b0;
      wakeReg   <= 1'b0;
    end else begin
      wakeReg <= 1'b0;
      if (pinRst) begin
        idlePend <= 1'b0;
        if (state != RSC_POWER_ON) begin // see R7
          state     <= RSC_IDLE; // see R6
          fromReset <= 1'b1;
        end
      end else begin
        if (rstPrev == 1'b0 && fromReset) begin
          wakeReg   <= 1'b1; // see R21
          fromReset <= 1'b0;
        end
        case (state)
          RSC_POWER_ON: if (cmdAnyIdle && oscReady) begin
            state   <= RSC_IDLE; // see R17
            wakeReg <= 1'b1;
          end
          RSC_SLEEP: if (!slp) begin
            state   <= RSC_IDLE; // see R5
            wakeReg <= 1'b1; // see R21
          end
          RSC_IDLE: if (slp) begin // see R4
            target <= RSC_SLEEP;
            cnt    <= 9'(`RSC_CLKOUT_STOP_CYC);
            state  <= fastStop ? RSC_PENDING : RSC_SLEEP; // see R18
          end else if (isCmd(`RSC_CMD_SYN_RDY)) begin
            target <= RSC_SYN_RDY;
            cnt    <= 9'(`RSC_REG_SETTLE_CYC); // see R22
            state  <= RSC_PENDING;
          end
          RSC_PENDING: if (cmdForceIdle) begin
            state <= RSC_IDLE; // see R8
          end else if (target == RSC_SYN_RDY) begin
            if (cnt == 9'h000) state <= RSC_SYN_RDY;
            else cnt <= cnt - 9'h001;
          end else if (!mclkOn || cnt == 9'h000) begin
            state <= target; // see R18
          end else if (mclkRise) begin
            cnt <= cnt - 9'h001;
          end
          RSC_SYN_RDY: if (cmdAnyIdle) begin
            state <= RSC_IDLE;
          end else if (isCmd(`RSC_CMD_LISTEN)) begin
            state <= RSC_LISTEN; // see R23
          end else if (isCmd(`RSC_CMD_TX_START) || (slp && !slpPrev)) begin
            state <= RSC_BUSY_TX; // see R4
          end
          RSC_LISTEN: if (cmdAnyIdle) begin
            state <= RSC_IDLE;
          end else if (isCmd(`RSC_CMD_FORCE_SYN) || isCmd(`RSC_CMD_SYN_RDY)) begin
            state <= RSC_SYN_RDY;
          end else if (slp && !slpPrev) begin
            target <= RSC_LISTEN_NC;
            cnt    <= 9'(`RSC_CLKOUT_STOP_CYC);
            state  <= fastStop ? RSC_PENDING : RSC_LISTEN_NC; // see R4
          end else if (frameStart && synthLock) begin
            state <= RSC_BUSY_RX; // see R23
          end
          RSC_LISTEN_NC: if (cmdForceIdle) begin // see R11
            state <= RSC_IDLE; // see R8
          end else if (!slp) begin
            state <= RSC_LISTEN; // see R5
          end else if (frameStart && synthLock) begin
            state <= RSC_BUSY_RX;
          end
          RSC_BUSY_RX, RSC_BUSY_TX: if (cmdForceIdle) begin
            state    <= RSC_IDLE; // see R8
            idlePend <= 1'b0;
          end else if (isCmd(`RSC_CMD_FORCE_SYN)) begin
            state    <= RSC_SYN_RDY; // see R10
            idlePend <= 1'b0;
          end else if (activityDone) begin
            idlePend <= 1'b0;
            if (idlePend || cmdIdle) state <= RSC_IDLE; // see R9
            else state <= (state == RSC_BUSY_RX) ? RSC_LISTEN : RSC_SYN_RDY;
          end else if (cmdIdle) begin
            idlePend <= 1'b1; // see R9
          end
          default: state <= RSC_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lockEvtReg <= 1'b0;
    end else begin
      lockEvtReg <= synthLock && !lockPrev && synthEn; // see R22
    end
  end

  // forced synth-ready keeps regulator and synth on; see R10
  assign synthEn      = state inside {RSC_SYN_RDY, RSC_LISTEN, RSC_LISTEN_NC,
                                      RSC_BUSY_RX, RSC_BUSY_TX};
  assign analogRegEn  = synthEn || (state == RSC_PENDING && target == RSC_SYN_RDY); // see R20
  assign rxEn         = state inside {RSC_LISTEN, RSC_LISTEN_NC, RSC_BUSY_RX};
  assign txEn         = state == RSC_BUSY_TX;
  assign pullsEn      = state == RSC_POWER_ON; // see R14
  assign clearBuffers = state == RSC_SLEEP; // see R19
  assign channel      = channelReg;
  assign wakeDoneEvt  = wakeReg;
  assign synthLockEvt = lockEvtReg;
  assign link.miso    = misoReg;
  assign link.mclk    = mclkReg;
endmodule : rsc_radio
`default_nettype wire

// File: inc/rsc_defines.svh
// constants for the radio state controller and its host
`ifndef RSC_DEFINES_SVH
`define RSC_DEFINES_SVH
`define RSC_CLK_NS         50
// device register map, 6-bit serial address
`define RSC_ADDR_READBACK  6'h01
`define RSC_ADDR_COMMAND   6'h02
`define RSC_ADDR_CTRL0     6'h03
`define RSC_ADDR_CHANNEL   6'h08
`define RSC_CTRL0_RST      8'h01
`define RSC_CHANNEL_RST    8'h0B
`define RSC_RATE_LSB       0
`define RSC_RATE_MSB       2
`define RSC_RATE_RST       3'h1
// state commands
`define RSC_CMD_NOP        5'h00
`define RSC_CMD_TX_START   5'h02
`define RSC_CMD_FORCE_IDLE 5'h03
`define RSC_CMD_FORCE_SYN  5'h04
`define RSC_CMD_LISTEN     5'h06
`define RSC_CMD_IDLE       5'h08
`define RSC_CMD_SYN_RDY    5'h09
// state readback codes
`define RSC_ST_POWER_ON    5'h00
`define RSC_ST_BUSY_RX     5'h01
`define RSC_ST_BUSY_TX     5'h02
`define RSC_ST_LISTEN      5'h06
`define RSC_ST_IDLE        5'h08
`define RSC_ST_SYN_RDY     5'h09
`define RSC_ST_SLEEP       5'h0F
`define RSC_ST_LISTEN_NC   5'h1C
`define RSC_ST_PENDING     5'h1F
// clock output rates: off, 1 MHz, 2 MHz, 250 kHz, 62.5 kHz
`define RSC_RATE_OFF       3'h0
`define RSC_RATE_1M        3'h1
`define RSC_RATE_2M        3'h2
`define RSC_RATE_250K      3'h3
`define RSC_RATE_62K       3'h4
`define RSC_HALF_1M        8'h0A
`define RSC_HALF_2M        8'h05
`define RSC_HALF_250K      8'h28
`define RSC_HALF_62K       8'hA0
`define RSC_CLKOUT_STOP_CYC 35
`define RSC_REG_SETTLE_NS  2000
`define RSC_REG_SETTLE_CYC ((`RSC_REG_SETTLE_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
// host side
`define RSC_HOST_HALF      8'h08
`define RSC_HADDR_CTRL     4'h0
`define RSC_HADDR_XFER     4'h1
`define RSC_HADDR_STATUS   4'h2
`endif

// File: inc/rsc_if.sv
// serial and control pins between host and radio
`timescale 1ns/1ps
`default_nettype none
interface rsc_if;
  logic selN;
  logic sclk;
  logic mosi;
  logic miso;
  logic sleepTx;
  logic rstPinN;
  logic mclk;
  modport dev  (input selN, sclk, mosi, sleepTx, rstPinN, output miso, mclk);
  modport host (output selN, sclk, mosi, sleepTx, rstPinN, input miso, mclk);
endinterface : rsc_if
`default_nettype wire

// File: inc/rsc_pkg.sv
// types of the radio state controller
package rsc_pkg;
  typedef enum logic [8:0] {
    RSC_POWER_ON  = 9'h001,
    RSC_SLEEP     = 9'h002,
    RSC_IDLE      = 9'h004,
    RSC_SYN_RDY   = 9'h008,
    RSC_LISTEN    = 9'h010,
    RSC_LISTEN_NC = 9'h020,
    RSC_BUSY_RX   = 9'h040,
    RSC_BUSY_TX   = 9'h080,
    RSC_PENDING   = 9'h100
  } rsc_state_t;
  typedef logic [4:0] rsc_code_t;
  typedef logic [7:0] rsc_byte_t;
endpackage : rsc_pkg

// File: test/rsc_properties.sv
// wire-level checks on the link between host and radio
`timescale 1ns/1ps
`default_nettype none
module rsc_properties (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // link
  input wire logic selN,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic sleepTx,
  input wire logic rstPinN,
  input wire logic mclk
);
  logic       mclkSeen_reg;
  logic       sclkPrev_reg;
  logic [4:0] riseCnt_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // first master clock pulse since power-on
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mclkSeen_reg <= 1'b0;
      sclkPrev_reg <= 1'b0;
    end else begin
      mclkSeen_reg <= mclkSeen_reg | mclk;
      sclkPrev_reg <= sclk;
    end
  end
  // serial clock rises within the current frame
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      riseCnt_reg <= 5'h00;
    end else if (selN) begin
      riseCnt_reg <= 5'h00;
    end else if (sclk && !sclkPrev_reg) begin
      riseCnt_reg <= riseCnt_reg + 5'h01;
    end
  end
  a_select_idle_clk: assert property (selN |-> !sclk)
    else $error("serial clock high while deselected");
  a_sclk_half_period: assert property ($changed(sclk) |=> $stable(sclk) [*7])
    else $error("serial clock half period too short");
  a_select_lead_in: assert property ($fell(selN) |=> !sclk [*6])
    else $error("serial clock rose too soon after select");
  a_mosi_hold_rise: assert property ($rose(sclk) |-> $stable(mosi))
    else $error("host data moved at a serial clock rise");
  a_miso_hold_rise: assert property ($rose(sclk) && !selN |-> $stable(miso))
    else $error("device data moved at a serial clock rise");
  a_frame_bit_count: assert property ($rose(selN) |-> riseCnt_reg == 5'h10)
    else $error("frame did not carry sixteen bits");
  a_no_early_access: assert property (!mclkSeen_reg |-> selN)
    else $error("link selected before master clock ran");
  a_pins_at_power_on: assert property (!mclkSeen_reg |-> rstPinN && !sleepTx)
    else $error("control pins not at defaults in power-on");
  c_frame_done: cover property ($rose(selN));
  c_sleep_pin: cover property ($rose(sleepTx));
  c_pin_reset: cover property ($fell(rstPinN));
endmodule : rsc_properties
`default_nettype wire

// File: test/tb_radio_state_controller.sv
// self-checking bench: host and radio joined over the link
`include "rsc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_radio_state_controller;
  import rsc_pkg::*;
  logic        clk;
  logic        rstn = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata;
  logic        oscReady = 1'b0;
  logic        synthLock = 1'b0;
  logic        frameStart = 1'b0;
  logic        activityDone = 1'b0;
  logic        analogRegEn, synthEn, rxEn, txEn, pullsEn, clearBuffers;
  rsc_byte_t   channel;
  logic        wakeDoneEvt, synthLockEvt, synPrev, mclkPrev;
  logic [15:0] s;
  logic [7:0]  q;
  int          n, fails = 0, checks_done = 0, wakeCnt = 0, lockCnt = 0;
  int          mclkRises = 0, regCnt = 0, regAtSyn = 0;
  rsc_if link ();
  rsc_host u_rsc_host (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .link(link));
  rsc_radio u_rsc_radio (.clk(clk), .rstn(rstn), .link(link), .oscReady(oscReady),
    .synthLock(synthLock), .frameStart(frameStart), .activityDone(activityDone),
    .analogRegEn(analogRegEn), .synthEn(synthEn), .rxEn(rxEn), .txEn(txEn),
    .pullsEn(pullsEn), .clearBuffers(clearBuffers), .channel(channel),
    .wakeDoneEvt(wakeDoneEvt), .synthLockEvt(synthLockEvt));
  rsc_properties u_rsc_properties (.clk(clk), .rstn(rstn), .selN(link.selN),
    .sclk(link.sclk), .mosi(link.mosi), .miso(link.miso), .sleepTx(link.sleepTx),
    .rstPinN(link.rstPinN), .mclk(link.mclk));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // event counters, sampled mid-cycle where outputs are settled
  always @(negedge clk) begin
    if (wakeDoneEvt === 1'b1) wakeCnt++;
    if (synthLockEvt === 1'b1) lockCnt++;
    if (link.mclk === 1'b1 && mclkPrev === 1'b0) mclkRises++;
    if (analogRegEn === 1'b1) regCnt++;
    else regCnt = 0;
    if (synthEn === 1'b1 && synPrev !== 1'b1) regAtSyn = regCnt;
    mclkPrev = link.mclk;
    synPrev = synthEn;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic sw_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : sw_wr
  task automatic sw_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : sw_rd
  // one serial frame; returns the byte seen during the data half
  task automatic xfer(input logic [15:0] w, output logic [7:0] b);
    logic [15:0] st;
    sw_wr(`RSC_HADDR_XFER, w);
    st = 16'h0001;
    for (int i = 0; i < 300 && st[0] !== 1'b0; i++) sw_rd(`RSC_HADDR_STATUS, st);
    b = st[15:8];
  endtask : xfer
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] b;
    xfer({2'h2, a, d}, b);
  endtask : wr_reg
  task automatic rd_reg(input logic [5:0] a, output logic [7:0] b);
    xfer({2'h0, a, 8'h00}, b);
  endtask : rd_reg
  task automatic cmd(input logic [4:0] c);
    wr_reg(`RSC_ADDR_COMMAND, {3'h0, c});
  endtask : cmd
  task automatic expect_st(input logic [4:0] c);
    logic [7:0] b;
    b = {3'h0, `RSC_ST_PENDING};
    for (int i = 0; i < 10 && b[4:0] === `RSC_ST_PENDING; i++) begin
      rd_reg(`RSC_ADDR_READBACK, b);
    end
    chk({3'h0, b[4:0]}, {3'h0, c});
  endtask : expect_st
  task automatic pulse(input bit done);
    @(posedge clk);
    if (done) activityDone <= 1'b1;
    else frameStart <= 1'b1;
    @(posedge clk);
    activityDone <= 1'b0;
    frameStart <= 1'b0;
  endtask : pulse
  task automatic pin_reset;
    sw_wr(`RSC_HADDR_CTRL, 16'h0002);
    repeat (10) @(posedge clk);
    sw_wr(`RSC_HADDR_CTRL, 16'h0000);
    repeat (10) @(posedge clk);
  endtask : pin_reset
  initial begin
    #(90000 * `RSC_CLK_NS);
    fails++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    oscReady <= 1'b1;
    @(negedge clk);
    chk({7'h00, pullsEn}, 8'h01);
    s = 16'h0000;
    for (n = 0; n < 300 && s[1] !== 1'b1; n++) sw_rd(`RSC_HADDR_STATUS, s);
    expect_st(`RSC_ST_POWER_ON);
    rd_reg(`RSC_ADDR_CTRL0, q);
    chk(q, `RSC_CTRL0_RST);
    rd_reg(`RSC_ADDR_CHANNEL, q);
    chk(q, `RSC_CHANNEL_RST);
    rd_reg(6'h3F, q);
    chk(q, 8'h00);
    pin_reset();
    expect_st(`RSC_ST_POWER_ON);
    chk(wakeCnt[7:0], 8'h00);
    cmd(`RSC_CMD_FORCE_SYN);
    expect_st(`RSC_ST_POWER_ON);
    cmd(`RSC_CMD_IDLE);
    expect_st(`RSC_ST_IDLE);
    chk(wakeCnt[7:0], 8'h01);
    chk({6'h00, pullsEn, analogRegEn}, 8'h00);
    wr_reg(`RSC_ADDR_CHANNEL, 8'h1A);
    chk(channel, 8'h1A);
    wr_reg(`RSC_ADDR_CTRL0, {5'h00, `RSC_RATE_2M});
    wr_reg(`RSC_ADDR_READBACK, 8'h06);
    expect_st(`RSC_ST_IDLE);
    mclkRises = 0;
    sw_wr(`RSC_HADDR_CTRL, 16'h0001);
    rd_reg(`RSC_ADDR_READBACK, q);
    chk({3'h0, q[4:0]}, {3'h0, `RSC_ST_PENDING});
    repeat (600) @(posedge clk);
    chk({7'h00, clearBuffers}, 8'h01);
    chk({7'h00, mclkRises >= 35 && mclkRises <= 36}, 8'h01);
    n = mclkRises;
    repeat (100) @(posedge clk);
    chk({7'h00, mclkRises == n}, 8'h01);
    sw_wr(`RSC_HADDR_CTRL, 16'h0000);
    expect_st(`RSC_ST_IDLE);
    chk(wakeCnt[7:0], 8'h02);
    rd_reg(`RSC_ADDR_CHANNEL, q);
    chk(q, 8'h1A);
    // clock output off, then a slow rate: both stop at once
    for (n = 0; n < 2; n++) begin
      wr_reg(`RSC_ADDR_CTRL0, {5'h00, ((n == 0) ? `RSC_RATE_OFF : `RSC_RATE_250K)});
      sw_wr(`RSC_HADDR_CTRL, 16'h0001);
      repeat (20) @(posedge clk);
      chk({7'h00, clearBuffers}, 8'h01);
      sw_wr(`RSC_HADDR_CTRL, 16'h0000);
      expect_st(`RSC_ST_IDLE);
    end
    wr_reg(`RSC_ADDR_CTRL0, {5'h00, `RSC_RATE_2M});
    cmd(`RSC_CMD_SYN_RDY);
    expect_st(`RSC_ST_SYN_RDY);
    chk({7'h00, regAtSyn >= `RSC_REG_SETTLE_CYC}, 8'h01);
    cmd(`RSC_CMD_LISTEN);
    expect_st(`RSC_ST_LISTEN);
    chk({7'h00, rxEn}, 8'h01);
    sw_wr(`RSC_HADDR_CTRL, 16'h0001);
    expect_st(`RSC_ST_LISTEN_NC);
    sw_wr(`RSC_HADDR_CTRL, 16'h0000);
    expect_st(`RSC_ST_LISTEN);
    pulse(1'b0);
    expect_st(`RSC_ST_LISTEN);
    synthLock <= 1'b1;
    repeat (10) @(posedge clk);
    chk(lockCnt[7:0], 8'h01);
    pulse(1'b0);
    expect_st(`RSC_ST_BUSY_RX);
    cmd(`RSC_CMD_IDLE);
    rd_reg(`RSC_ADDR_READBACK, q);
    chk({7'h00, q[4:0] === `RSC_ST_IDLE}, 8'h00);
    pulse(1'b1);
    expect_st(`RSC_ST_IDLE);
    cmd(`RSC_CMD_SYN_RDY);
    expect_st(`RSC_ST_SYN_RDY);
    cmd(`RSC_CMD_LISTEN);
    expect_st(`RSC_ST_LISTEN);
    pulse(1'b0);
    expect_st(`RSC_ST_BUSY_RX);
    cmd(`RSC_CMD_FORCE_SYN);
    expect_st(`RSC_ST_SYN_RDY);
    chk({6'h00, analogRegEn, synthEn}, 8'h03);
    sw_wr(`RSC_HADDR_CTRL, 16'h0001);
    expect_st(`RSC_ST_BUSY_TX);
    chk({7'h00, txEn}, 8'h01);
    sw_wr(`RSC_HADDR_CTRL, 16'h0000);
    cmd(`RSC_CMD_FORCE_SYN);
    expect_st(`RSC_ST_SYN_RDY);
    cmd(`RSC_CMD_TX_START);
    expect_st(`RSC_ST_BUSY_TX);
    cmd(`RSC_CMD_FORCE_IDLE);
    expect_st(`RSC_ST_IDLE);
    chk({7'h00, analogRegEn}, 8'h00);
    cmd(`RSC_CMD_FORCE_SYN);
    expect_st(`RSC_ST_IDLE);
    pin_reset();
    expect_st(`RSC_ST_IDLE);
    chk(wakeCnt[7:0], 8'h05);
    rd_reg(`RSC_ADDR_CHANNEL, q);
    chk(q, `RSC_CHANNEL_RST);
    chk(channel, `RSC_CHANNEL_RST);
    rd_reg(`RSC_ADDR_CTRL0, q);
    chk(q, {5'h00, `RSC_RATE_2M});
    close_out();
  end
endmodule : tb_radio_state_controller
`default_nettype wire
